// ===== design/core_seq_pkg.sv
// shared constants, enums and structs for the core memory and interrupt sequencer
package core_seq_pkg;
  // program counter / flash words
  localparam int PC_W = 13;
  localparam logic [1:0] VARIANT_DEF = 2'h2;
  // data address map boundaries
  localparam int DADDR_W = 16;
  localparam logic [15:0] REGFILE_END = 16'h001F;
  localparam logic [15:0] STDIO_BASE = 16'h0020;
  localparam logic [15:0] STDIO_END = 16'h005F;
  localparam logic [15:0] EXTIO_BASE = 16'h0060;
  localparam logic [15:0] EXTIO_END = 16'h00FF;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  localparam logic [15:0] SRAM_SIZE_V0 = 16'h0200;
  localparam logic [15:0] SRAM_SIZE_V1 = 16'h0400;
  localparam logic [5:0] DISP_MAX = 6'h3F;
  // nonvolatile sizes
  localparam logic [9:0] NV_SIZE_V0 = 10'h100;
  localparam logic [9:0] NV_SIZE_V1 = 10'h200;
  // cycle counts
  localparam logic [3:0] IRQ_ENTRY_CYC = 4'h4;
  localparam logic [3:0] IRQ_WAKE_EXTRA = 4'h4;
  localparam logic [3:0] VEC_JMP_CYC = 4'h3;
  localparam logic [3:0] RETURN_FROM_IRQ_INSTR_CYC = 4'h4;
  localparam logic [3:0] SRAM_CYC = 4'h2;
  localparam logic [3:0] NV_RD_STALL = 4'h4;
  localparam logic [3:0] NV_WR_STALL = 4'h2;
  localparam logic [15:0] SP_RETURN_FROM_IRQ_INSTR_INC = 16'h0002;
  // self-timed write, 3.4 ms at 100 ns per cycle
  localparam int NV_WRITE_US = 3400;
  localparam int CLK_NS = 100;
  localparam int NV_WRITE_CYC = (NV_WRITE_US * 1000) / CLK_NS;
  localparam int IRQ_N = 26;
  localparam int IRQ_IDX_W = 5;

  typedef enum logic [1:0] {
    REG_FILE = 2'h0,
    STD_IO = 2'h1,
    EXT_IO = 2'h2,
    SRAM_RGN = 2'h3
  } region_e;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STALL = 3'b001,
    ST_IRQ = 3'b011,
    ST_RETURN_FROM_IRQ_INSTR = 3'b010,
    ST_WAKE = 3'b110
  } seq_state_e;

  typedef enum logic [2:0] {
    AM_DIRECT = 3'h0,
    AM_DISP = 3'h1,
    AM_IND = 3'h2,
    AM_PREDEC = 3'h3,
    AM_POSTINC = 3'h4,
    AM_IO = 3'h5
  } addr_mode_e;

  // one memory reference from the pipeline
  typedef struct packed {
    logic valid;
    logic wr;
    addr_mode_e mode;
    logic [1:0] ptr_sel;
    logic [5:0] disp;
    logic [15:0] abs_addr;
  } mem_req_s;

  // decoded reference toward the memories
  typedef struct packed {
    logic valid;
    logic wr;
    region_e region;
    logic mapped;
    logic [15:0] addr;
  } mem_sel_s;
endpackage

// ===== design/data_addr_decode.sv
// data address formation and region decode for the pointer addressing modes
module data_addr_decode import core_seq_pkg::*; (
  // request and pointer values
  input wire mem_req_s req,
  input wire logic [15:0] ptr_val,
  input wire logic [1:0] variant,
  // decoded result and pointer write-back
  output mem_sel_s sel,
  output logic [15:0] ptr_new,
  output logic ptr_we
);
  logic [15:0] base_addr;
  logic [15:0] eff_addr;
  logic [15:0] sram_end;
  logic is_sram;

  // direct reaches all of data space; io form only has 64 locations
  assign base_addr = (req.mode == AM_PREDEC) ? ptr_val - 16'h0001 : ptr_val; // RQ15
  assign eff_addr = (req.mode == AM_DIRECT) ? req.abs_addr : // RQ13
    (req.mode == AM_IO) ? STDIO_BASE + {10'h000, req.abs_addr[5:0]} : // RQ11 RQ12
    (req.mode == AM_DISP) ? base_addr + {10'h000, req.disp & DISP_MAX} : base_addr; // RQ14
  assign sram_end = SRAM_BASE + ((variant == 2'h0) ? SRAM_SIZE_V0 : SRAM_SIZE_V1) - 16'h0001;
  assign is_sram = (eff_addr >= SRAM_BASE);

  // region order: registers, standard io, extended io, sram
  assign sel.valid = req.valid;
  assign sel.wr = req.wr;
  assign sel.addr = eff_addr;
  assign sel.region = (eff_addr <= REGFILE_END) ? REG_FILE : // RQ10
    (eff_addr <= STDIO_END) ? STD_IO : (eff_addr <= EXTIO_END) ? EXT_IO : SRAM_RGN;
  assign sel.mapped = !is_sram || (eff_addr <= sram_end); // RQ27

  // pre-decrement and post-increment write the pointer back
  assign ptr_we = req.valid && (req.mode == AM_PREDEC || req.mode == AM_POSTINC); // RQ15
  assign ptr_new = (req.mode == AM_POSTINC) ? ptr_val + 16'h0001 : base_addr;
endmodule

// ===== design/nv_write_timer.sv
// self-timed nonvolatile write busy timer that survives core reset
module nv_write_timer import core_seq_pkg::*; #(
  parameter int WRITE_CYC = NV_WRITE_CYC
) (
  // clock and power-on reset only
  input wire logic core_clk,
  input wire logic npor,
  // start and status
  input wire logic start,
  output logic busy
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // count down while busy; core reset does not reach this counter
  assign cnt_d = (start && cnt_q == 16'h0000) ? 16'(WRITE_CYC) :
    (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q; // RQ21 RQ22
  assign busy = (cnt_q != 16'h0000);

  always_ff @(posedge core_clk or negedge npor) begin
    if (!npor) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ===== design/core_mem_irq_seq.sv
// core sequencer: interrupt entry/return timing, memory stalls, address decode
// What this block does
// RQ1 - after enabling interrupts, one more instruction runs before a pending interrupt
// RQ2 - interrupt entry takes four cycles, pushes program counter, then vector runs
// RQ3 - the jump at a vector takes three cycles
// RQ4 - a multi-cycle instruction finishes before interrupt entry begins
// RQ5 - waking from sleep adds four cycles to interrupt entry
// RQ6 - return from interrupt takes four cycles, pops counter, stack plus two, enables
// RQ7 - program memory is 16-bit words; instructions take one or two words
// RQ8 - program counter is 11, 12 or 13 bits by variant
// RQ9 - smallest variant has no boot section; program store allowed anywhere
// RQ10 - data map: 32 registers, 64 io, 160 extended io, then sram
// RQ11 - extended io 0x60 to 0xFF only through data load and store
// RQ12 - short io instructions encode only 64 locations
// RQ13 - direct addressing reaches all data space
// RQ14 - displacement mode adds up to 63 to middle or high pointer
// RQ15 - pre-decrement and post-increment write the pointer back
// RQ16 - registers 26 to 31 form the three pointer pairs
// RQ17 - each sram access takes two cycles
// RQ18 - nonvolatile data space is 256 or 512 bytes, byte addressed
// RQ19 - nonvolatile read stalls the core four cycles
// RQ20 - nonvolatile write stalls the core two cycles
// RQ21 - nonvolatile writes are self-timed and busy is visible to software
// RQ22 - a write in progress completes across a core reset
// RQ23 - interrupt entry clears the global enable
// RQ24 - after return, one main instruction runs before the next interrupt
// RQ25 - lowest pending vector wins
// RQ26 - stalls hold the counter and block fetch and register writes
// RQ27 - addresses past implemented sram are unmapped
module core_mem_irq_seq import core_seq_pkg::*; #(
  parameter int NV_WR_CYC = NV_WRITE_CYC
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic npor,
  input wire logic [1:0] variant,
  // instruction pipeline
  input wire logic instr_done,
  input wire logic instr_two_word,
  input wire logic [PC_W-1:0] pc_next,
  input wire logic sei_exec,
  input wire logic cli_exec,
  input wire logic return_from_irq_instr_exec,
  input wire logic jmp_exec,
  input wire logic store_pgm_exec,
  input wire logic asleep,
  input wire mem_req_s mem_req,
  input wire logic nv_rd_trig,
  input wire logic nv_wr_trig,
  input wire logic [9:0] nv_addr,
  // interrupt sources and stack
  input wire logic [IRQ_N-1:0] irq_pend,
  input wire logic [15:0] stack_ptr,
  input wire logic [7:0] stack_rd_data,
  // register file pointer pairs r26..r31
  input wire logic [47:0] ptr_regs,
  // sequencer outputs
  output logic stall,
  output logic fetch_en,
  output logic rf_we_en,
  output logic [PC_W-1:0] program_counter,
  output logic gie,
  output logic irq_ack,
  output logic [IRQ_IDX_W-1:0] irq_idx,
  output logic [15:0] sp_next,
  output logic sp_we,
  output logic pc_push,
  output logic [7:0] push_data,
  output logic store_pgm_ok,
  output mem_sel_s mem_sel,
  output logic [15:0] ptr_new,
  output logic [1:0] ptr_pair,
  output logic ptr_we,
  output logic nv_busy,
  output logic nv_addr_ok
);
  seq_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic gie_q, gie_d;
  logic hold_q, hold_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [IRQ_IDX_W-1:0] idx_q;
  logic [7:0] pop_lo_q;
  logic [15:0] ptr_val;
  logic [PC_W-1:0] pc_mask;
  logic irq_any, take_irq, sram_acc, nv_start, cnt_last;
  logic [3:0] stall_len;

  // lowest pending index is the highest priority
  function automatic logic [IRQ_IDX_W-1:0] prio_enc(input logic [IRQ_N-1:0] p);
    logic [IRQ_IDX_W-1:0] r;
    r = '0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = IRQ_IDX_W'(i);
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // address decode and pointer select
  assign ptr_pair = (mem_req.mode == AM_DISP && mem_req.ptr_sel == 2'h0) ? 2'h1 : mem_req.ptr_sel; // RQ14
  assign ptr_val = (ptr_pair == 2'h0) ? ptr_regs[15:0] : // RQ16
    (ptr_pair == 2'h1) ? ptr_regs[31:16] : ptr_regs[47:32];

  data_addr_decode u_dec (
    .req(mem_req),
    .ptr_val(ptr_val),
    .variant(variant),
    .sel(mem_sel),
    .ptr_new(ptr_new),
    .ptr_we(ptr_we)
  );

  // write timer keeps its own reset so core reset cannot abort a write
  nv_write_timer #(.WRITE_CYC(NV_WR_CYC)) u_nvt (
    .core_clk(core_clk),
    .npor(npor),
    .start(nv_start),
    .busy(nv_busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // variant-dependent widths
  assign pc_mask = (variant == 2'h0) ? 13'h07FF : (variant == 2'h1) ? 13'h0FFF : 13'h1FFF; // RQ8
  assign nv_addr_ok = (variant == 2'h0) ? (nv_addr < NV_SIZE_V0) : (nv_addr < NV_SIZE_V1); // RQ18
  // program store is legal everywhere on the smallest part; larger parts need the counter inside pc_mask
  assign store_pgm_ok = store_pgm_exec && (variant == 2'h0 || (pc_q & ~pc_mask) == '0); // RQ9
  // a new write is ignored while the previous one is still burning
  assign nv_start = nv_wr_trig && !nv_busy; // RQ21

  //////////////////////////////////////////////////////////////////////////////
  // sequencing decisions
  assign irq_any = |irq_pend;
  // hold_q blocks service for one instruction after sei or return
  assign take_irq = (state_q == ST_RUN) && instr_done && gie_q && irq_any && // RQ4
    !cli_exec && !hold_q && !sei_exec; // RQ1 RQ24
  assign sram_acc = mem_sel.valid && mem_sel.region == SRAM_RGN && mem_sel.mapped;
  assign stall_len = nv_rd_trig ? NV_RD_STALL - 4'h1 : nv_start ? NV_WR_STALL - 4'h1 : // RQ19 RQ20
    jmp_exec ? VEC_JMP_CYC - 4'h1 : SRAM_CYC - 4'h1; // RQ3 RQ17
  assign cnt_last = (cnt_q == 4'h1);

  // next state and counters
  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
    gie_d = gie_q;
    hold_d = hold_q;
    pc_d = (instr_done && state_q == ST_RUN) ? (pc_next & pc_mask) : pc_q; // RQ7 RQ26
    if (sei_exec) begin
      gie_d = 1'b1;
    end
    if (cli_exec) begin
      gie_d = 1'b0;
    end
    if (instr_done && hold_q && !sei_exec) begin
      hold_d = 1'b0;
    end
    case (state_q)
      ST_RUN: begin
        if (sei_exec && !gie_q) begin
          hold_d = 1'b1; // RQ1
        end
        if (take_irq) begin
          state_d = asleep ? ST_WAKE : ST_IRQ; // RQ5
          cnt_d = asleep ? IRQ_WAKE_EXTRA : IRQ_ENTRY_CYC; // RQ2
          gie_d = 1'b0; // RQ23
        end else if (return_from_irq_instr_exec) begin
          state_d = ST_RETURN_FROM_IRQ_INSTR;
          cnt_d = RETURN_FROM_IRQ_INSTR_CYC; // RQ6
        end else if (nv_rd_trig || nv_start || jmp_exec || (sram_acc && instr_done)) begin
          state_d = ST_STALL;
          cnt_d = stall_len;
        end
      end
      ST_WAKE: begin
        if (cnt_last) begin
          state_d = ST_IRQ;
          cnt_d = IRQ_ENTRY_CYC; // RQ5
        end
      end
      ST_IRQ: begin
        if (cnt_last) begin
          state_d = ST_RUN;
          pc_d = {{(PC_W - IRQ_IDX_W - 1){1'b0}}, idx_q, 1'b0} & pc_mask; // RQ2
        end
      end
      ST_RETURN_FROM_IRQ_INSTR: begin
        // counter reloads only on the way out, so it stays frozen during the stall
        if (cnt_last) begin
          state_d = ST_RUN;
          pc_d = {stack_rd_data[PC_W-9:0], pop_lo_q} & pc_mask; // RQ6 RQ26
          gie_d = 1'b1; // RQ6
          hold_d = 1'b1; // RQ24
        end
      end
      ST_STALL: begin
        if (cnt_last) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
        cnt_d = 4'h0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_RUN;
      cnt_q <= 4'h0;
      gie_q <= 1'b0;
      hold_q <= 1'b0;
      pc_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      gie_q <= gie_d;
      hold_q <= hold_d;
      pc_q <= pc_d;
    end
  end

  // captured vector index and low popped byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= '0;
      pop_lo_q <= 8'h00;
    end else begin
      idx_q <= take_irq ? prio_enc(irq_pend) : idx_q; // RQ25
      pop_lo_q <= (state_q == ST_RETURN_FROM_IRQ_INSTR && cnt_q == 4'h3) ? stack_rd_data : pop_lo_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs; stalls freeze fetch, counter and register writes
  assign stall = (state_q != ST_RUN); // RQ26
  assign fetch_en = !stall;
  assign rf_we_en = !stall;
  assign program_counter = pc_q;
  assign gie = gie_q;
  assign irq_ack = take_irq;
  assign irq_idx = idx_q;
  assign pc_push = (state_q == ST_IRQ) && (cnt_q == 4'h4 || cnt_q == 4'h3); // RQ2
  assign push_data = (cnt_q == 4'h4) ? pc_q[7:0] : 8'(pc_q[PC_W-1:8]);
  assign sp_we = pc_push || ((state_q == ST_RETURN_FROM_IRQ_INSTR) && cnt_last);
  assign sp_next = (state_q == ST_RETURN_FROM_IRQ_INSTR) ? stack_ptr + SP_RETURN_FROM_IRQ_INSTR_INC : stack_ptr - 16'h0001; // RQ6

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence entry_hold_s;
    stall [*4];
  endsequence
  irq_entry_len_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ2
    (take_irq && !asleep) |=> entry_hold_s ##1 !stall) else $error("entry not four cycles");
  return_from_irq_instr_len_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ6
    (state_q == ST_RUN && return_from_irq_instr_exec && !take_irq) |=> stall [*4] ##1 (!stall && gie))
    else $error("return not four cycles");
  entry_gie_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ23
    take_irq |=> !gie) else $error("enable not cleared on entry");
  sei_delay_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ1
    (state_q == ST_RUN && sei_exec && !gie) |=> !take_irq)
    else $error("irq taken right after enable");
  nv_rd_stall_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ19
    (state_q == ST_RUN && nv_rd_trig && !take_irq && !return_from_irq_instr_exec) |=> stall [*3] ##1 !stall)
    else $error("read stall wrong");
  wake_len_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ5
    (take_irq && asleep) |=> stall [*8] ##1 !stall) else $error("wake entry wrong");
  stall_fetch_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ26
    stall |=> $stable(program_counter) || !stall) else $error("pc moved during stall");
  vec_prio_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ25
    take_irq |=> irq_idx == prio_enc($past(irq_pend))) else $error("wrong vector chosen");

  // entry pushes two bytes back to back; the short stalls each have a fixed length
  sequence push_pair_s;
    pc_push ##1 pc_push ##1 !pc_push;
  endsequence
  sequence jmp_hold_s;
    stall [*2] ##1 !stall;
  endsequence
  logic plain_run;
  assign plain_run = (state_q == ST_RUN) && !take_irq && !return_from_irq_instr_exec && !nv_rd_trig;
  push_pair_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ2
    (take_irq && !asleep) |=> push_pair_s) else $error("pc not pushed in two bytes");
  vec_pc_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ2
    (state_q == ST_IRQ && cnt_last) |=> program_counter == PC_W'({irq_idx, 1'b0}))
    else $error("vector address wrong");
  jmp_len_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ3
    (plain_run && !nv_start && jmp_exec) |=> jmp_hold_s) else $error("jump stall wrong");
  nv_wr_stall_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ20
    (plain_run && nv_start) |=> stall ##1 !stall) else $error("write stall wrong");
  sram_len_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ17
    (plain_run && !nv_start && !jmp_exec && sram_acc && instr_done) |=> stall ##1 !stall)
    else $error("sram stall wrong");
  ret_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ24
    (state_q == ST_RETURN_FROM_IRQ_INSTR && cnt_last) |=> !take_irq)
    else $error("irq taken right after return");
endmodule

// ===== tb/stack_model.sv
// behavioural stack memory and stack pointer standing behind the sequencer
module stack_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // push and pointer update from the sequencer
  input wire logic pc_push,
  input wire logic [7:0] push_data,
  input wire logic sp_we,
  input wire logic [15:0] sp_next,
  // pointer and pop data back to the sequencer
  output logic [15:0] stack_ptr,
  output logic [7:0] stack_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [16];
  logic [3:0] off_q;
  ////////////////////////////////////////////////////////////////////////////
  // pushes land at the pointer; the pointer itself moves only on sp_we
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stack_ptr <= 16'h04FF;
      off_q <= 4'h0;
    end else begin
      if (pc_push) begin
        mem_q[4'(stack_ptr) - off_q] <= push_data;
        off_q <= off_q + 4'h1;
      end
      if (sp_we) begin
        stack_ptr <= sp_next;
        off_q <= 4'h0;
      end
    end
  end
  // only the top byte is modelled; deeper pops are not checked
  assign stack_rd_data = mem_q[4'(stack_ptr + 16'h0001)];
endmodule

// ===== tb/tb.sv
// self-checking bench for the core memory and interrupt sequencer
module tb import core_seq_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, nrst = 1'b0, npor = 1'b0;
  logic [1:0] variant = 2'h0;
  logic instr_done = 1'b0, instr_two_word = 1'b0, sei_exec = 1'b0, cli_exec = 1'b0;
  logic return_from_irq_instr_exec = 1'b0, jmp_exec = 1'b0, store_pgm_exec = 1'b0, asleep = 1'b0;
  logic nv_rd_trig = 1'b0, nv_wr_trig = 1'b0;
  logic [PC_W-1:0] pc_next = '0;
  mem_req_s mem_req = '0;
  logic [9:0] nv_addr = 10'h000;
  logic [IRQ_N-1:0] irq_pend = '0;
  logic [15:0] stack_ptr, sp_next, ptr_new, sp_seen, sp0, push_seen;
  logic [7:0] stack_rd_data, push_data;
  logic [47:0] ptr_regs = 48'h0200_0180_0150;
  logic stall, fetch_en, rf_we_en, gie, irq_ack, sp_we, pc_push, store_pgm_ok;
  logic ptr_we, nv_busy, nv_addr_ok;
  logic [PC_W-1:0] program_counter;
  logic [IRQ_IDX_W-1:0] irq_idx;
  logic [1:0] ptr_pair;
  mem_sel_s mem_sel;
  int bad_count = 0, compares = 0, n_st, n_push, n_fe;
  // short write time keeps the busy wait brief
  core_mem_irq_seq #(.NV_WR_CYC(20)) core_mem_irq_seq_i (.core_clk(core_clk), .nrst(nrst),
    .npor(npor), .variant(variant), .instr_done(instr_done), .instr_two_word(instr_two_word),
    .pc_next(pc_next), .sei_exec(sei_exec), .cli_exec(cli_exec), .return_from_irq_instr_exec(return_from_irq_instr_exec),
    .jmp_exec(jmp_exec), .store_pgm_exec(store_pgm_exec), .asleep(asleep), .mem_req(mem_req),
    .nv_rd_trig(nv_rd_trig), .nv_wr_trig(nv_wr_trig), .nv_addr(nv_addr), .irq_pend(irq_pend),
    .stack_ptr(stack_ptr), .stack_rd_data(stack_rd_data), .ptr_regs(ptr_regs), .stall(stall),
    .fetch_en(fetch_en), .rf_we_en(rf_we_en), .program_counter(program_counter), .gie(gie),
    .irq_ack(irq_ack), .irq_idx(irq_idx), .sp_next(sp_next), .sp_we(sp_we), .pc_push(pc_push),
    .push_data(push_data), .store_pgm_ok(store_pgm_ok), .mem_sel(mem_sel), .ptr_new(ptr_new),
    .ptr_pair(ptr_pair), .ptr_we(ptr_we), .nv_busy(nv_busy), .nv_addr_ok(nv_addr_ok));
  stack_model stack_model_i (.core_clk(core_clk), .nrst(nrst), .pc_push(pc_push),
    .push_data(push_data), .sp_we(sp_we), .sp_next(sp_next), .stack_ptr(stack_ptr),
    .stack_rd_data(stack_rd_data));
  ////////////////////////////////////////////////////////////////////////////
  // clock, and the last stack pointer update seen
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (sp_we === 1'b1) sp_seen <= sp_next;
  always @(posedge core_clk) if (pc_push === 1'b1) push_seen <= {push_seen[7:0], push_data};
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one instruction completes at the next edge
  task automatic go;
    @(posedge core_clk);
    instr_done <= 1'b1;
  endtask
  // drop every pulse, then count stall cycles under a bound
  task automatic run;
    int k;
    @(posedge core_clk);
    {instr_done, sei_exec, return_from_irq_instr_exec, jmp_exec, nv_rd_trig, nv_wr_trig} <= '0;
    store_pgm_exec <= 1'b0;
    mem_req.valid <= 1'b0;
    #1;
    n_st = 0;
    n_push = 0;
    n_fe = 0;
    for (k = 0; k < 30 && stall === 1'b1; k++) begin
      n_st++;
      if (pc_push === 1'b1) n_push++;
      if (fetch_en !== 1'b0 || rf_we_en !== 1'b0) n_fe++;
      @(posedge core_clk);
      #1;
    end
    if (k == 30) begin
      bad_count++;
      end_of_test();
    end
  endtask
  // region map across every boundary, smallest variant
  task automatic t_decode;
    logic [15:0] ad [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100,
                            16'h02FF, 16'h0300};
    logic [1:0] rg [8] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
    for (int i = 0; i < 8; i++) begin
      mem_req <= '{1'b0, 1'b0, AM_DIRECT, 2'h0, 6'h00, ad[i]};
      @(posedge core_clk);
      #1;
      chk("region", {14'h0, mem_sel.region}, {14'h0, rg[i]});
      chk("mapped", {15'h0, mem_sel.mapped}, {15'h0, i != 7});
    end
    mem_req <= '{1'b0, 1'b0, AM_IO, 2'h0, 6'h00, 16'h003F};
    @(posedge core_clk);
    #1;
    chk("io addr", mem_sel.addr, 16'h005F);
    mem_req <= '{1'b0, 1'b0, AM_DISP, 2'h2, 6'h3F, 16'h0000};
    @(posedge core_clk);
    #1;
    chk("disp addr", mem_sel.addr, 16'h023F);
    mem_req <= '{1'b1, 1'b0, AM_POSTINC, 2'h0, 6'h00, 16'h0000};
    @(posedge core_clk);
    #1;
    chk("inc addr", mem_sel.addr, 16'h0150);
    chk("inc ptr", ptr_new, 16'h0151);
    chk("inc we", {14'h0, ptr_pair, ptr_we}, 16'h0001);
    mem_req <= '{1'b1, 1'b0, AM_PREDEC, 2'h1, 6'h00, 16'h0000};
    @(posedge core_clk);
    #1;
    chk("dec addr", mem_sel.addr, 16'h017F);
    chk("dec we", {14'h0, ptr_pair, ptr_we}, 16'h0003);
    nv_addr <= 10'h0FF;
    mem_req.valid <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("nv ok", {15'h0, nv_addr_ok}, 16'h0001);
    nv_addr <= 10'h100;
    @(posedge core_clk);
    #1;
    chk("nv out", {15'h0, nv_addr_ok}, 16'h0000);
  endtask
  // counter width, program store and the fixed stalls
  task automatic t_stalls;
    int k;
    go();
    pc_next <= 13'h1FFF;
    store_pgm_exec <= 1'b1;
    #1;
    chk("pgm ok", {15'h0, store_pgm_ok}, 16'h0001);
    run();
    chk("pc", {3'h0, program_counter}, 16'h07FF);
    go();
    jmp_exec <= 1'b1;
    run();
    chk("jmp stall", 16'(n_st), 16'h0002);
    go();
    mem_req <= '{1'b1, 1'b0, AM_DIRECT, 2'h0, 6'h00, 16'h0100};
    run();
    chk("sram stall", 16'(n_st), 16'h0001);
    chk("hold", 16'(n_fe), 16'h0000);
    go();
    nv_rd_trig <= 1'b1;
    run();
    chk("nv rd stall", 16'(n_st), 16'h0003);
    go();
    nv_wr_trig <= 1'b1;
    run();
    chk("nv wr stall", 16'(n_st), 16'h0001);
    chk("busy", {15'h0, nv_busy}, 16'h0001);
    go();
    nv_wr_trig <= 1'b1;
    run();
    chk("refused", 16'(n_st), 16'h0000);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    chk("busy reset", {15'h0, nv_busy}, 16'h0001);
    for (k = 0; k < 30 && nv_busy === 1'b1; k++) @(posedge core_clk);
    #1;
    chk("busy done", {15'h0, nv_busy}, 16'h0000);
    if (k == 30) end_of_test();
  endtask
  // enable, entry, return, then a wake from sleep
  task automatic t_irq;
    irq_pend <= 26'h28;
    go();
    sei_exec <= 1'b1;
    @(posedge core_clk);
    sei_exec <= 1'b0;
    #1;
    chk("after enable", {15'h0, irq_ack}, 16'h0000);
    @(posedge core_clk);
    #1;
    chk("ack", {15'h0, irq_ack}, 16'h0001);
    run();
    chk("entry", 16'(n_st), 16'h0004);
    chk("push", 16'(n_push), 16'h0002);
    chk("hold", 16'(n_fe), 16'h0000);
    chk("gie off", {15'h0, gie}, 16'h0000);
    chk("index", {11'h0, irq_idx}, 16'h0003);
    chk("vector", {3'h0, program_counter}, 16'h0006);
    chk("push data", push_seen, 16'hFF07);
    sp0 = stack_ptr;
    go();
    return_from_irq_instr_exec <= 1'b1;
    run();
    chk("return", 16'(n_st), 16'h0004);
    chk("gie on", {15'h0, gie}, 16'h0001);
    chk("sp", sp_seen, sp0 + 16'h0002);
    go();
    #1;
    chk("after return", {15'h0, irq_ack}, 16'h0000);
    @(posedge core_clk);
    asleep <= 1'b1;
    #1;
    chk("wake ack", {15'h0, irq_ack}, 16'h0001);
    run();
    chk("wake entry", 16'(n_st), 16'h0008);
    asleep <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    npor <= 1'b1;
    #1;
    chk("reset stall", {15'h0, stall}, 16'h0000);
    t_decode();
    t_stalls();
    t_irq();
    end_of_test();
  end
endmodule
